// [design/pss_pkg.sv]
package pss_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NPTS = 16;                // Discrete points per image
    localparam int NLOOPS = 16;              // Loop capacity of the larger variant
    localparam int CLK_MHZ = 125;
    localparam int WDOG_MS = 200;            // Factory watchdog limit
    localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
    localparam logic [15:0] LOOP_IVAL_RST = 16'h0004;

    // ------------------------------------------------------------
    // Scan segments, Gray coded along the cycle
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEG_IN   = 4'h0,
        SEG_SPIN = 4'h1,
        SEG_PERI = 4'h3,
        SEG_BUS  = 4'h2,
        SEG_CLK  = 4'h6,
        SEG_PROG = 4'h7,
        SEG_LOOP = 4'h5,
        SEG_OUT  = 4'h4,
        SEG_SPOUT = 4'hC,
        SEG_DIAG = 4'h8                  // One bit from SPOUT and from IN, so the wrap stays Gray too
    } pss_seg_e;

    // Peripheral request
    typedef struct packed {
        logic force_req;                     // Regular force
        logic ovr_set;                       // Enable override
        logic ovr_clr;                       // Remove override
        logic is_out;                        // 1: output image, 0: input image
        logic [3:0] idx;
        logic val;
    } pss_peri_s;

    // Program result for one rung
    typedef struct packed {
        logic valid;
        logic last;                          // End coil
        logic drives_out;
        logic [3:0] idx;
        logic val;
    } pss_rung_s;

endpackage : pss_pkg

// [design/pss_loop_sched.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Loop scheduler: runs only configured loops whose interval elapsed
// ------------------------------------------------------------
module pss_loop_sched #(
    parameter int NL = pss_pkg::NLOOPS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [NL-1:0] cfg,
    input wire logic [15:0] ival,
    output logic busy,
    output logic [NL-1:0] run_mask
);
    localparam int PW = $clog2(NL);
    logic [15:0] tick_q [NL];
    logic [$clog2(NL)-1:0] ptr_q;
    logic busy_q;
    logic [NL-1:0] run_q;
    wire logic due = cfg[ptr_q] && (tick_q[ptr_q] >= ival);

    assign busy = busy_q;
    assign run_mask = run_q;

    // One loop examined per cycle; unconfigured loops cost one cycle only
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            ptr_q <= '0;
            run_q <= '0;
            for (int i = 0; i < NL; i++) tick_q[i] <= 16'h0000;
        end else if (start && !busy_q) begin
            busy_q <= 1'b1;
            ptr_q <= '0;
            run_q <= '0;
        end else if (busy_q) begin
            run_q[ptr_q] <= due;
            tick_q[ptr_q] <= due ? 16'h0000 : tick_q[ptr_q] + 16'h0001;
            ptr_q <= ptr_q + 1'b1;
            if (ptr_q == PW'(NL - 1)) busy_q <= 1'b0;
        end
    end
endmodule : pss_loop_sched

// [design/pss_scan_seq.sv]
`timescale 1ns/1ps
// Contract
// - Run entered by mode switch, or by programmer when switch is remote.
// - During a run-mode edit, outputs hold their last value.
// - Edit with an error turns outputs off and enters program mode.
// - Input stage samples all local inputs into the input image.
// - Immediate read fetches the module input directly, lengthening the scan; here the read adds no cycles to the program segment.
// - Specialty and remote inputs collected after local inputs.
// - Peripherals serviced after input collection; requests modify images.
// - Regular force lasts until the location is rewritten next scan.
// - Override freezes a bit against physical changes.
// - Forcing still works on overridden points and persists.
// - Overridden points never take program or I/O updates.
// - Bus modules exchanged only on local base in their own segment.
// - Clock, calendar and special relays refreshed every scan.
// - Program evaluated rung by rung to the end coil.
// - Relays, stages and variable memory updated during evaluation.
// - Rung results replace forces; unused outputs keep forces.
// - Only configured loops computed after ladder, per scheduler interval.
// - Output image copied to local and expansion outputs.
// - Then specialty and remote outputs sent.
// - Outputs refreshed only in run; off in program; inputs still read.
// - Fatal error gives program mode with outputs off.
// - Watchdog bounds evaluation; overrun gives program mode, outputs off.
module pss_scan_seq #(
    parameter int WDOG_CYCLES = pss_pkg::WDOG_CYC,
    parameter int NL = pss_pkg::NLOOPS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sw_run,
    input wire logic sw_remote,
    input wire logic prog_run_cmd,
    input wire logic prog_stop_cmd,
    input wire logic edit_active,
    input wire logic edit_error,
    input wire logic fatal_err,
    input wire logic nonfatal_err,
    input wire logic [pss_pkg::NPTS-1:0] local_in,
    input wire logic [pss_pkg::NPTS-1:0] remote_in,
    input wire logic [pss_pkg::NPTS-1:0] spec_in,
    input wire pss_pkg::pss_peri_s peri,
    input wire logic bus_done,
    input wire logic [31:0] rtc_now,
    input wire pss_pkg::pss_rung_s rung,
    input wire logic imm_req,
    input wire logic [3:0] imm_idx,
    input wire logic [NL-1:0] loop_cfg,
    input wire logic [15:0] loop_ival,
    output logic run_mode,
    output logic [3:0] seg,
    output logic rung_ready,
    output logic imm_val,
    output logic bus_en,
    output logic [pss_pkg::NPTS-1:0] local_out,
    output logic [pss_pkg::NPTS-1:0] remote_out,
    output logic [pss_pkg::NPTS-1:0] in_image,
    output logic [31:0] rtc_image,
    output logic [NL-1:0] loop_run,
    output logic wdog_err,
    output logic err_report
);
    localparam int NP = pss_pkg::NPTS;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pss_pkg::pss_seg_e seg_q, seg_d;
    logic run_q;
    logic [NP-1:0] xin_q, yout_q, xovr_q, yovr_q;
    logic [NP-1:0] lout_q, rout_q;
    logic [31:0] rtc_q;
    logic [31:0] wd_q;
    logic wderr_q, errrep_q, busen_q, rdy_q, imm_q;
    logic lp_busy, lp_start_q;
    logic [NL-1:0] lp_mask, lrun_q;

    // Override-gated merge: frozen bits keep the image value
    function automatic logic [NP-1:0] merge(input logic [NP-1:0] img, input logic [NP-1:0] nw,
                                             input logic [NP-1:0] ovr);
        merge = (img & ovr) | (nw & ~ovr);
    endfunction : merge

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire logic want_run = sw_remote ? prog_run_cmd : sw_run;
    wire logic want_stop = sw_remote ? prog_stop_cmd : !sw_run;
    wire logic wd_over = (seg_q == pss_pkg::SEG_PROG) && (wd_q >= 32'(WDOG_CYCLES - 1));
    wire logic drop_run = fatal_err || (edit_active && edit_error) || wd_over;
    wire logic hold_out = edit_active && !edit_error;
    wire logic prog_step = rung.valid && (seg_q == pss_pkg::SEG_PROG) && run_q;
    wire logic prog_end = !run_q || (prog_step && rung.last);
    wire logic [NP-1:0] ibit = NP'(1) << imm_idx;

    // Next segment; out of run, program and loop segments pass in one cycle each
    always_comb begin
        seg_d = seg_q;
        unique case (seg_q)
            pss_pkg::SEG_IN: seg_d = pss_pkg::SEG_SPIN;
            pss_pkg::SEG_SPIN: seg_d = pss_pkg::SEG_PERI;
            pss_pkg::SEG_PERI: seg_d = pss_pkg::SEG_BUS;
            pss_pkg::SEG_BUS: if (bus_done) seg_d = pss_pkg::SEG_CLK;
            pss_pkg::SEG_CLK: seg_d = pss_pkg::SEG_PROG;
            pss_pkg::SEG_PROG: if (prog_end || wd_over) seg_d = pss_pkg::SEG_LOOP;
            pss_pkg::SEG_LOOP: if (!lp_busy && !lp_start_q) seg_d = pss_pkg::SEG_OUT;
            pss_pkg::SEG_OUT: seg_d = pss_pkg::SEG_SPOUT;
            pss_pkg::SEG_SPOUT: seg_d = pss_pkg::SEG_DIAG;
            pss_pkg::SEG_DIAG: seg_d = pss_pkg::SEG_IN;
            default: seg_d = pss_pkg::SEG_IN;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and mode
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            seg_q <= pss_pkg::SEG_IN;
            run_q <= 1'b0;
        end else begin
            seg_q <= seg_d;
            if (drop_run) run_q <= 1'b0;
            else if (seg_q == pss_pkg::SEG_DIAG && want_run) run_q <= 1'b1;
            else if (want_stop) run_q <= 1'b0;
        end
    end

    // Watchdog counts only the evaluation segment
    always_ff @(posedge clk) begin
        if (srst || seg_q != pss_pkg::SEG_PROG) wd_q <= 32'h0000_0000;
        else wd_q <= wd_q + 32'h0000_0001;
    end

    // Errors are reported; non-fatal ones leave the mode alone
    always_ff @(posedge clk) begin
        if (srst) begin
            wderr_q <= 1'b0;
            errrep_q <= 1'b0;
        end else begin
            if (wd_over) wderr_q <= 1'b1;
            else if (want_run && !run_q && seg_q == pss_pkg::SEG_DIAG) wderr_q <= 1'b0;
            errrep_q <= fatal_err || nonfatal_err || wd_over || (edit_active && edit_error);
        end
    end

    // ------------------------------------------------------------
    // Input image: sample, then overlay specialty and remote, then forces
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            xin_q <= '0;
            xovr_q <= '0;
        end else begin
            if (seg_q == pss_pkg::SEG_IN) xin_q <= merge(xin_q, local_in, xovr_q);
            if (seg_q == pss_pkg::SEG_SPIN) xin_q <= merge(xin_q, local_in | spec_in | remote_in, xovr_q);
            if (seg_q == pss_pkg::SEG_PERI && !peri.is_out) begin
                if (peri.force_req) xin_q[peri.idx] <= peri.val;
                if (peri.ovr_set) xovr_q[peri.idx] <= 1'b1;
                else if (peri.ovr_clr) xovr_q[peri.idx] <= 1'b0;
            end
        end
    end

    // Output image: forces, then rung results that overwrite them
    always_ff @(posedge clk) begin
        if (srst) begin
            yout_q <= '0;
            yovr_q <= '0;
        end else begin
            if (seg_q == pss_pkg::SEG_PERI && peri.is_out) begin
                if (peri.force_req) yout_q[peri.idx] <= peri.val;
                if (peri.ovr_set) yovr_q[peri.idx] <= 1'b1;
                else if (peri.ovr_clr) yovr_q[peri.idx] <= 1'b0;
            end
            if (prog_step && rung.drives_out && !yovr_q[rung.idx]) yout_q[rung.idx] <= rung.val;
        end
    end

    // Physical outputs: off out of run, frozen during an edit
    always_ff @(posedge clk) begin
        if (srst || !run_q || drop_run) begin
            lout_q <= '0;
            rout_q <= '0;
        end else if (!hold_out) begin
            if (seg_q == pss_pkg::SEG_OUT) lout_q <= yout_q;
            if (seg_q == pss_pkg::SEG_SPOUT) rout_q <= yout_q;
        end
    end

    // Clock refresh, bus window, rung handshake and immediate read
    always_ff @(posedge clk) begin
        if (srst) begin
            rtc_q <= 32'h0000_0000;
            busen_q <= 1'b0;
            rdy_q <= 1'b0;
            imm_q <= 1'b0;
        end else begin
            if (seg_q == pss_pkg::SEG_CLK) rtc_q <= rtc_now;
            busen_q <= (seg_d == pss_pkg::SEG_BUS);
            rdy_q <= (seg_d == pss_pkg::SEG_PROG) && run_q && !drop_run;
            if (imm_req && seg_q == pss_pkg::SEG_PROG) imm_q <= |(local_in & ibit);
        end
    end

    // ------------------------------------------------------------
    // Loops
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lp_start_q <= 1'b0;
            lrun_q <= '0;
        end else begin
            lp_start_q <= (seg_d == pss_pkg::SEG_LOOP) && (seg_q != pss_pkg::SEG_LOOP) && run_q;
            if (seg_q == pss_pkg::SEG_OUT) lrun_q <= lp_mask;
        end
    end

    pss_loop_sched #(.NL(NL)) u_sched (
        .clk(clk),
        .srst(srst),
        .start(lp_start_q),
        .cfg(loop_cfg),
        .ival(loop_ival),
        .busy(lp_busy),
        .run_mask(lp_mask)
    );

    assign run_mode = run_q;
    assign seg = seg_q;
    assign rung_ready = rdy_q;
    assign imm_val = imm_q;
    assign bus_en = busen_q;
    assign local_out = lout_q;
    assign remote_out = rout_q;
    assign in_image = xin_q;
    assign rtc_image = rtc_q;
    assign loop_run = lrun_q;
    assign wdog_err = wderr_q;
    assign err_report = errrep_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_prog_outs_off: assert property (@(posedge clk) disable iff (srst) !run_q |=> local_out == '0)
        else $error("outputs on outside run");
    chk_fatal_to_prog: assert property (@(posedge clk) disable iff (srst) fatal_err |=> !run_mode && local_out == '0)
        else $error("fatal error kept run");
    chk_edit_err_stop: assert property (@(posedge clk) disable iff (srst) edit_active && edit_error |=> !run_mode)
        else $error("edit error kept run");
    chk_edit_hold: assert property (@(posedge clk) disable iff (srst) hold_out && run_q && !drop_run |=> $stable(local_out))
        else $error("outputs moved during edit");
    chk_seg_order: assert property (@(posedge clk) disable iff (srst) seg_q == pss_pkg::SEG_IN |=> seg_q == pss_pkg::SEG_SPIN ##1 seg_q == pss_pkg::SEG_PERI)
        else $error("segment order broken");
    chk_in_sample: assert property (@(posedge clk) disable iff (srst) seg_q == pss_pkg::SEG_IN && xovr_q == '0 |=> in_image == $past(local_in))
        else $error("input image not sampled");
    chk_ovr_freeze: assert property (@(posedge clk) disable iff (srst) seg_q == pss_pkg::SEG_IN |=> ((in_image ^ $past(xin_q)) & $past(xovr_q)) == '0)
        else $error("overridden input changed");
    chk_out_copy: assert property (@(posedge clk) disable iff (srst) seg_q == pss_pkg::SEG_OUT && run_q && !hold_out && !drop_run |=> local_out == $past(yout_q))
        else $error("output image not copied");
    chk_rtc_refresh: assert property (@(posedge clk) disable iff (srst) seg_q == pss_pkg::SEG_CLK |=> rtc_image == $past(rtc_now))
        else $error("clock not refreshed");
    chk_wdog_bound: assert property (@(posedge clk) disable iff (srst) wd_over |=> !run_mode ##1 wdog_err)
        else $error("watchdog overrun ignored");
    cov_run_entry: cover property (@(posedge clk) disable iff (srst) !run_q ##1 run_q);
    cov_edit_hold: cover property (@(posedge clk) disable iff (srst) hold_out && seg_q == pss_pkg::SEG_OUT && run_q);
    cov_force_ovr: cover property (@(posedge clk) disable iff (srst) peri.force_req && peri.is_out && yovr_q[peri.idx]);
    cov_loop_run: cover property (@(posedge clk) disable iff (srst) lp_mask != '0 && seg_q == pss_pkg::SEG_OUT);
endmodule : pss_scan_seq

// [verif/pss_far_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote master and bus module model
// ------------------------------------------------------------
module pss_far_model #(
    parameter int DLY = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] seg,
    input wire logic bus_en,
    input wire logic [15:0] remote_out,
    output logic bus_done,
    output logic [15:0] remote_in,
    output logic [15:0] applied_q
);
    logic [3:0] wait_q;
    logic [7:0] scan_q;

    // Fresh data every scan, high byte only, so low-byte checks see no remote bits
    assign remote_in = {scan_q, 8'h00};

    // Bus module stalls a few cycles, never answers at once
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q <= 4'h0;
            bus_done <= 1'b0;
        end else begin
            bus_done <= bus_en && !bus_done && (wait_q == 4'(DLY));
            wait_q <= (bus_en && !bus_done) ? wait_q + 4'h1 : 4'h0;
        end
    end

    // Outputs sent in the specialty output segment reach the slaves when the next scan enters its input segment
    always_ff @(posedge clk) begin
        if (srst) begin
            scan_q <= 8'h00;
            applied_q <= 16'h0000;
        end else begin
            if (seg == pss_pkg::SEG_DIAG) begin
                scan_q <= scan_q + 8'h01;
            end
            if (seg == pss_pkg::SEG_IN) begin
                applied_q <= remote_out;
            end
        end
    end
endmodule : pss_far_model

// [verif/pss_scan_seq_test.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Scan sequencer bench
// ------------------------------------------------------------
module pss_scan_seq_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sw_run = 1'b0, sw_remote = 1'b0, prog_run_cmd = 1'b0, prog_stop_cmd = 1'b0;
    logic edit_active = 1'b0, edit_error = 1'b0, fatal_err = 1'b0, nonfatal_err = 1'b0;
    logic [15:0] local_in = 16'h0000, spec_in = 16'h0000, remote_in, remote_out, local_out, in_image, applied;
    pss_pkg::pss_peri_s peri = '0;
    pss_pkg::pss_rung_s rung = '0;
    logic bus_done, imm_req = 1'b0, imm_val, bus_en, run_mode, rung_ready, wdog_err, err_report;
    logic [3:0] imm_idx = 4'h0, seg, loop_cfg = 4'h0, loop_run;
    logic [15:0] loop_ival = 16'h0001;
    logic [31:0] rtc_now = 32'h0, rtc_image;
    int err_count = 0, samples_checked = 0, cyc = 0;

    always #4 clk = ~clk;

    // Shortened watchdog and the four-loop variant keep the run brief
    pss_scan_seq #(.WDOG_CYCLES(50), .NL(4)) u_pss_scan_seq (.clk(clk), .srst(srst), .sw_run(sw_run),
        .sw_remote(sw_remote), .prog_run_cmd(prog_run_cmd), .prog_stop_cmd(prog_stop_cmd),
        .edit_active(edit_active), .edit_error(edit_error), .fatal_err(fatal_err), .nonfatal_err(nonfatal_err),
        .local_in(local_in), .remote_in(remote_in), .spec_in(spec_in), .peri(peri), .bus_done(bus_done),
        .rtc_now(rtc_now), .rung(rung), .imm_req(imm_req), .imm_idx(imm_idx), .loop_cfg(loop_cfg),
        .loop_ival(loop_ival), .run_mode(run_mode), .seg(seg), .rung_ready(rung_ready), .imm_val(imm_val),
        .bus_en(bus_en), .local_out(local_out), .remote_out(remote_out), .in_image(in_image),
        .rtc_image(rtc_image), .loop_run(loop_run), .wdog_err(wdog_err), .err_report(err_report));
    pss_far_model #(.DLY(2)) u_pss_far_model (.clk(clk), .srst(srst), .seg(seg), .bus_en(bus_en),
        .remote_out(remote_out), .bus_done(bus_done), .remote_in(remote_in), .applied_q(applied));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    // Sample one step after the edge so every update has landed
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic wait_seg(input logic [3:0] s);
        int n;
        n = 0;
        do begin
            step();
            n++;
        end while (seg !== s && n < 2000);
        chk(n < 2000, "segment wait ran out");
    endtask : wait_seg
    task automatic wait_run(input logic want);
        int n;
        n = 0;
        while (run_mode !== want && n < 500) begin
            step();
            n++;
        end
        chk(run_mode === want, "run mode change missing");
    endtask : wait_run
    // Request fields: force, override set, override clear, output image, index, value
    task automatic send_peri(input logic [8:0] p);
        wait_seg(pss_pkg::SEG_SPIN);
        @(posedge clk) peri <= p;
        wait_seg(pss_pkg::SEG_BUS);
        @(posedge clk) peri <= '0;
    endtask : send_peri

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_prog_mode;
        @(posedge clk) local_in <= 16'h0003;
        wait_seg(pss_pkg::SEG_SPIN);
        wait_seg(pss_pkg::SEG_PERI);
        chk(in_image[1:0] === 2'b11, "inputs not read in program mode");
        chk(local_out === 16'h0000, "outputs on in program mode");
        $display("test prog_mode done");
    endtask : t_prog_mode
    task automatic t_order;
        logic [3:0] exp [10];
        logic [3:0] prev;
        int n;
        exp = '{pss_pkg::SEG_IN, pss_pkg::SEG_SPIN, pss_pkg::SEG_PERI, pss_pkg::SEG_BUS, pss_pkg::SEG_CLK,
            pss_pkg::SEG_PROG, pss_pkg::SEG_LOOP, pss_pkg::SEG_OUT, pss_pkg::SEG_SPOUT, pss_pkg::SEG_DIAG};
        @(posedge clk) sw_run <= 1'b1;
        spec_in <= 16'h0020;
        rtc_now <= 32'h1234_5678;
        rung <= {3'b111, 4'h4, 1'b1};
        wait_run(1'b1);
        wait_seg(pss_pkg::SEG_IN);
        for (int i = 1; i < 10; i++) begin
            prev = seg;
            n = 0;
            while (seg === prev && n < 500) begin
                step();
                n++;
            end
            chk(seg === exp[i], "segment out of order");
            if (exp[i] == pss_pkg::SEG_PROG) chk(rung_ready === 1'b1, "rung handshake missing");
        end
        chk(rtc_image === 32'h1234_5678, "clock image stale");
        chk(local_out[4] === 1'b1, "rung result not written out");
        wait_seg(pss_pkg::SEG_PERI);
        chk(applied[4] === 1'b1, "remote output not sent");
        chk(in_image[15:8] === remote_in[15:8], "remote inputs not collected");
        chk(in_image[5] === 1'b1, "specialty input not collected");
        $display("test order done");
    endtask : t_order
    task automatic t_force;
        send_peri({4'b1000, 4'h2, 1'b1});
        wait_seg(pss_pkg::SEG_CLK);
        chk(in_image[2] === 1'b1, "input force not stored");
        wait_seg(pss_pkg::SEG_BUS);
        chk(in_image[2] === 1'b0, "input force outlived rescan");
        send_peri({4'b1001, 4'h6, 1'b1});
        send_peri({4'b1001, 4'h4, 1'b0});
        wait_seg(pss_pkg::SEG_DIAG);
        chk(local_out[6] === 1'b1, "unused output lost force");
        chk(local_out[4] === 1'b1, "rung did not replace force");
        $display("test force done");
    endtask : t_force
    task automatic t_ovr;
        send_peri({4'b0100, 4'h3, 1'b0});
        @(posedge clk) local_in[3] <= 1'b1;
        wait_seg(pss_pkg::SEG_IN);
        wait_seg(pss_pkg::SEG_BUS);
        chk(in_image[3] === 1'b0, "override bit followed input");
        send_peri({4'b1000, 4'h3, 1'b1});
        @(posedge clk) local_in[3] <= 1'b0;
        wait_seg(pss_pkg::SEG_IN);
        wait_seg(pss_pkg::SEG_BUS);
        chk(in_image[3] === 1'b1, "force on override lost");
        send_peri({4'b0010, 4'h3, 1'b0});
        wait_seg(pss_pkg::SEG_IN);
        wait_seg(pss_pkg::SEG_BUS);
        chk(in_image[3] === 1'b0, "cleared override still frozen");
        $display("test override done");
    endtask : t_ovr
    task automatic t_imm_loops;
        logic [3:0] acc;
        wait_seg(pss_pkg::SEG_CLK);
        @(posedge clk) local_in[7] <= 1'b1;
        imm_req <= 1'b1;
        imm_idx <= 4'h7;
        loop_cfg <= 4'h5;
        wait_seg(pss_pkg::SEG_LOOP);
        chk(imm_val === 1'b1, "immediate read missed module");
        chk(in_image[7] === 1'b0, "immediate read touched image");
        @(posedge clk) imm_req <= 1'b0;
        local_in[7] <= 1'b0;
        acc = 4'h0;
        for (int i = 0; i < 4; i++) begin
            wait_seg(pss_pkg::SEG_OUT);
            chk((loop_run & 4'hA) === 4'h0, "unconfigured loop ran");
            acc = acc | loop_run;
        end
        chk(|acc === 1'b1, "no configured loop ran");
        $display("test imm_loops done");
    endtask : t_imm_loops
    task automatic t_edit;
        @(posedge clk) edit_active <= 1'b1;
        rung <= {3'b111, 4'h4, 1'b0};
        wait_seg(pss_pkg::SEG_IN);
        wait_seg(pss_pkg::SEG_DIAG);
        chk(local_out[4] === 1'b1, "output moved during edit");
        @(posedge clk) edit_error <= 1'b1;
        step();
        step();
        chk(local_out === 16'h0000, "outputs on after bad edit");
        chk(run_mode === 1'b0, "run kept after bad edit");
        @(posedge clk) edit_error <= 1'b0;
        edit_active <= 1'b0;
        sw_run <= 1'b0;
        $display("test edit done");
    endtask : t_edit
    task automatic t_errors;
        logic seen;
        @(posedge clk) rung <= {3'b111, 4'h4, 1'b1};
        sw_run <= 1'b1;
        wait_run(1'b1);
        wait_seg(pss_pkg::SEG_DIAG);
        @(posedge clk) nonfatal_err <= 1'b1;
        seen = 1'b0;
        // The report stands only while the error does, so look before lowering it
        repeat (2) begin
            step();
            seen = seen | (err_report === 1'b1);
        end
        @(posedge clk) nonfatal_err <= 1'b0;
        chk(seen === 1'b1, "non-fatal error not reported");
        chk(run_mode === 1'b1, "non-fatal error left run");
        @(posedge clk) fatal_err <= 1'b1;
        @(posedge clk) fatal_err <= 1'b0;
        step();
        chk(run_mode === 1'b0 && local_out === 16'h0000, "fatal error kept run");
        @(posedge clk) sw_run <= 1'b0;
        sw_remote <= 1'b1;
        prog_run_cmd <= 1'b1;
        wait_run(1'b1);
        @(posedge clk) rung <= {3'b101, 4'h4, 1'b1};
        repeat (300) begin
            if (wdog_err !== 1'b1) begin
                step();
            end
        end
        chk(wdog_err === 1'b1, "watchdog silent");
        chk(run_mode === 1'b0 && local_out === 16'h0000, "overrun kept run");
        @(posedge clk) rung <= {3'b111, 4'h4, 1'b1};
        wait_run(1'b1);
        chk(wdog_err === 1'b0, "watchdog flag kept after run entry");
        @(posedge clk) prog_run_cmd <= 1'b0;
        prog_stop_cmd <= 1'b1;
        wait_run(1'b0);
        step();
        chk(local_out === 16'h0000, "outputs on after remote stop");
        $display("test errors done");
    endtask : t_errors

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Hang guard, well above the several hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_prog_mode();
        t_order();
        t_force();
        t_ovr();
        t_imm_loops();
        t_edit();
        t_errors();
        give_verdict();
    end
endmodule : pss_scan_seq_test
